// [src/output_disable_request_detector.sv]
/*
 * Output disable request detector: four active-low request pins, per-pin mode,
 * sticky request flags, interrupt request and a twelve-pin high-impedance force,
 * with the control/status register reached over AXI4-Lite.
 * Assumes request pins synchronous enough for a two-flop synchroniser, one clock,
 * synchronous active-low reset acting as the power-on reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odr_defines.svh"

// Notes on behaviour
// - A pin's flag sets when that pin shows the condition its mode field selects, pin 1 in bits 3:2.
// - A flag clears only by writing 0 after reading it as 1; writing 1 does nothing; reset gives 0.
// - Flags of pins 2, 1 and 0 sit at bits 14, 13 and 12 of the control/status register.
// - Pin 3's flag sits at bit 15 and sets on the condition chosen by bits 7:6.
// - Bits 11:9 are reserved, always read 0, and software writes only 0 there.
// - With the enable at bit 8 set, any set flag raises the interrupt request; cleared, none.
// - Mode fields: pin 3 bits 7:6, pin 2 bits 5:4, pin 1 bits 3:2, pin 0 bits 1:0, reset 00.
// - Mode 00 accepts a request on a high-to-low transition of the pin.
// - Modes 01, 10, 11 sample the pin 16 times at clk/8, /16, /128 and accept when all are low.
// - The 16 low samples must be consecutive; one high sample rejects the run.
// - An accepted request on any pin forces all twelve motor timer phase outputs to high impedance.
// - The delay from sampling to high impedance is the same for edge and level detection.
// - High impedance is released only by reset or once all four flags are clear.
module output_disable_request_detector
	import odr_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Request pins, active low
	input  wire logic [`REQ_PINS-1:0] hiz_request_pin_n,
	// Motor timer phase outputs forced off, high while forced
	output var  logic [`HIZ_PINS-1:0] motor_hiz_force,
	output var  logic                 request_irq,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]    awaddr,
	input  wire logic                 awvalid,
	output var  logic                 awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output var  logic                 wready,
	output var  logic [1:0]           bresp,
	output var  logic                 bvalid,
	input  wire logic                 bready,
	input  wire logic [ADDR_W-1:0]    araddr,
	input  wire logic                 arvalid,
	output var  logic                 arready,
	output var  logic [31:0]          rdata,
	output var  logic [1:0]           rresp,
	output var  logic                 rvalid,
	input  wire logic                 rready
);

	// Refuse address widths that cannot hold the map
	if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie in 3..32");
	end

	localparam logic [ADDR_W-1:0] CSR_ADDR = ADDR_W'(`CSR_ADDR);

	// ****************************************
	// Control and status state
	// ****************************************
	logic [`REQ_PINS-1:0]            flag_q;
	logic [`REQ_PINS-1:0]            flag_d;
	logic [`REQ_PINS-1:0]            armed_q;
	logic [`REQ_PINS-1:0]            clear_hit;
	logic [`REQ_PINS-1:0]            accept;
	logic                            irq_en_q;
	logic [`REQ_PINS*`CSR_MODE_W-1:0] mode_q;
	logic [15:0]                     csr_view;

	// ****************************************
	// Bus slave state
	// ****************************************
	logic [ADDR_W-1:0] awaddr_q;
	logic              aw_full_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              w_full_q;
	logic              do_write;
	logic              wr_hit;
	logic              rd_take;
	logic              rd_hit;

	// ****************************************
	// Sampling ticks and per-pin detectors
	// ****************************************
	logic tick_div8;
	logic tick_div16;
	logic tick_div128;

	// Shared prescaler for all pins
	sample_prescaler u_prescaler (
		.clk         (clk),
		.rst_n       (rst_n),
		.tick_div8   (tick_div8),
		.tick_div16  (tick_div16),
		.tick_div128 (tick_div128)
	);

	// One detector per request pin
	for (genvar i = 0; i < `REQ_PINS; i++) begin : g_pin
		pin_detector #(
			.RUN_LEN (`SAMPLE_RUN)
		) u_det (
			.clk         (clk),
			.rst_n       (rst_n),
			.pin_n       (hiz_request_pin_n[i]),
			.mode        (sample_mode_t'(mode_q[i*`CSR_MODE_W +: `CSR_MODE_W])),
			.tick_div8   (tick_div8),
			.tick_div16  (tick_div16),
			.tick_div128 (tick_div128),
			.accept      (accept[i])
		);
	end

	// ****************************************
	// Register view and decode
	// ****************************************

	// Read value; reserved bits forced to zero
	always_comb begin
		csr_view = `CSR_RESET;
		csr_view[`CSR_FLAG_LSB +: `REQ_PINS] = flag_q;
		csr_view[`CSR_RSVD_MSB:`CSR_RSVD_LSB] = '0;
		csr_view[`CSR_IRQ_EN_BIT] = irq_en_q;
		csr_view[`CSR_MODE_LSB +: `REQ_PINS*`CSR_MODE_W] = mode_q;
	end

	// Write and read handshakes and hits
	assign do_write = aw_full_q & w_full_q & ~bvalid;
	assign wr_hit   = ({awaddr_q[ADDR_W-1:2], 2'b00} == CSR_ADDR);
	assign rd_take  = arvalid & arready;
	assign rd_hit   = ({araddr[ADDR_W-1:2], 2'b00} == CSR_ADDR);

	// Flags cleared by a zero written after a read of one
	always_comb begin
		clear_hit = '0;
		if (do_write && wr_hit && wstrb_q[1]) begin
			clear_hit = armed_q & ~wdata_q[`CSR_FLAG_LSB +: `REQ_PINS];
		end
	end

	// New events win over a clear in the same cycle
	assign flag_d = (flag_q & ~clear_hit) | accept;

	// ****************************************
	// Flags and clear arming
	// ****************************************

	// Sticky request flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// A flag read as one arms its clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_q <= '0;
		end else if (rd_take && rd_hit) begin
			armed_q <= (armed_q & ~clear_hit) | flag_q;
		end else begin
			armed_q <= armed_q & ~clear_hit & flag_q;
		end
	end

	// ****************************************
	// Control fields
	// ****************************************

	// Mode fields and interrupt enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q   <= '0;
			irq_en_q <= 1'b0;
		end else if (do_write && wr_hit) begin
			if (wstrb_q[0]) begin
				mode_q <= wdata_q[`CSR_MODE_LSB +: `REQ_PINS*`CSR_MODE_W];
			end
			if (wstrb_q[1]) begin
				irq_en_q <= wdata_q[`CSR_IRQ_EN_BIT];
			end
		end
	end

	// ****************************************
	// Outputs to the motor timer and interrupt
	// ****************************************

	// Force held while any flag stands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			motor_hiz_force <= '0;
		end else begin
			motor_hiz_force <= {`HIZ_PINS{|flag_d}};
		end
	end

	// Interrupt request level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			request_irq <= 1'b0;
		end else begin
			request_irq <= irq_en_q & (|flag_d);
		end
	end

	// ****************************************
	// AXI4-Lite write channels
	// ****************************************

	// Write address capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awready   <= 1'b1;
			aw_full_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			aw_full_q <= 1'b1;
			awaddr_q  <= awaddr;
		end else if (do_write) begin
			aw_full_q <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	// Write data capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wready   <= 1'b1;
			w_full_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			w_full_q <= 1'b1;
			wdata_q  <= wdata;
			wstrb_q  <= wstrb;
		end else if (do_write) begin
			w_full_q <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// Write response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read channels
	// ****************************************

	// Read address take and data answer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `RESP_OKAY;
		end else if (rd_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_hit ? {16'h0000, csr_view} : 32'h0000_0000;
			rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule : output_disable_request_detector

`default_nettype wire

// [src/odr_defines.svh]
/*
 * Offsets, field positions, reset values and counts of the output disable request detector.
 * Assumes inclusion by bare name from design files; holds definitions only.
 */
`ifndef ODR_DEFINES_SVH
`define ODR_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define CSR_ADDR        12'h000
`define CSR_RESET       16'h0000
`define CSR_FLAG_LSB    12
`define CSR_IRQ_EN_BIT  8
`define CSR_RSVD_MSB    11
`define CSR_RSVD_LSB    9
`define CSR_MODE_LSB    0
`define CSR_MODE_W      2

// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// ****************************************
// Counts
// ****************************************
`define REQ_PINS        4
`define HIZ_PINS        12
`define SAMPLE_RUN      16
`define PRESCALE_W      7

`endif

// [src/odr_pkg.sv]
/*
 * Types shared by the output disable request detector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package odr_pkg;

	// Per-pin input mode field
	typedef enum logic [1:0] {
		MODE_EDGE   = 2'b00,
		MODE_DIV8   = 2'b01,
		MODE_DIV16  = 2'b10,
		MODE_DIV128 = 2'b11
	} sample_mode_t;

endpackage : odr_pkg

// [src/sample_prescaler.sv]
/*
 * Free-running prescaler giving one-cycle sampling ticks at clk/8, clk/16 and clk/128.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odr_defines.svh"

module sample_prescaler (
	input  wire logic clk,
	input  wire logic rst_n,
	output var  logic tick_div8,
	output var  logic tick_div16,
	output var  logic tick_div128
);

	logic [`PRESCALE_W-1:0] count_q;

	// Free-running count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	// Registered ticks, one clk wide each
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_div8   <= 1'b0;
			tick_div16  <= 1'b0;
			tick_div128 <= 1'b0;
		end else begin
			tick_div8   <= (count_q[2:0] == 3'h7);
			tick_div16  <= (count_q[3:0] == 4'hF);
			tick_div128 <= (count_q == 7'h7F);
		end
	end

endmodule : sample_prescaler

`default_nettype wire

// [src/pin_detector.sv]
/*
 * One request pin: synchroniser, falling-edge detector and low-level run counter.
 * Assumes sampling ticks from the shared prescaler, synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "odr_defines.svh"

module pin_detector
	import odr_pkg::*;
#(
	parameter int RUN_LEN = `SAMPLE_RUN
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         pin_n,
	input  wire sample_mode_t mode,
	input  wire logic         tick_div8,
	input  wire logic         tick_div16,
	input  wire logic         tick_div128,
	output var  logic         accept
);

	localparam int RUN_W = $clog2(RUN_LEN);
	localparam logic [RUN_W-1:0] RUN_LAST = RUN_W'(RUN_LEN - 1);

	// Refuse runs the counter cannot serve
	if (RUN_LEN < 2) begin : g_bad_run
		$error("RUN_LEN must be at least 2");
	end

	logic             sync1_q;
	logic             sync2_q;
	logic             prev_q;
	logic [RUN_W-1:0] run_q;
	logic             sample_tick;

	// Two-flop synchroniser and edge history
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q  <= 1'b1;
		end else begin
			sync1_q <= pin_n;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Sampling clock chosen by the mode field
	always_comb begin
		case (mode)
			MODE_DIV8:   sample_tick = tick_div8;
			MODE_DIV16:  sample_tick = tick_div16;
			MODE_DIV128: sample_tick = tick_div128;
			default:     sample_tick = 1'b0;
		endcase
	end

	// Consecutive low samples; one high sample restarts the run
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q <= '0;
		end else if (mode == MODE_EDGE) begin
			run_q <= '0;
		end else if (sample_tick) begin
			if (sync2_q || run_q == RUN_LAST) begin
				run_q <= '0;
			end else begin
				run_q <= run_q + 1'b1;
			end
		end
	end

	// Accept pulse, same one-clk register stage for both detection kinds
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			accept <= 1'b0;
		end else if (mode == MODE_EDGE) begin
			accept <= prev_q & ~sync2_q;
		end else begin
			accept <= sample_tick & ~sync2_q & (run_q == RUN_LAST);
		end
	end

endmodule : pin_detector

`default_nettype wire

// [testbench/fault_source.sv]
/*
 * Fault source model: drives the active-low request pins from bench levels.
 * Assumes levels change just after a rising clock edge; pins idle high.
 */
`timescale 1ns/1ps
`default_nettype none
module fault_source (
	input  wire logic       clk,
	input  wire logic [3:0] level_n,
	input  wire logic       slow,
	output var  logic [3:0] pin_n
);
	initial pin_n = 4'hF;
	// Follow the bench off the clock edge, two cycles later when slow
	always @(level_n) begin
		if (slow) begin
			repeat (2) @(posedge clk);
		end
		#3 pin_n = level_n;
	end
endmodule : fault_source
`default_nettype wire

// [testbench/odr_sva.sv]
/*
 * Port checker of the output disable request detector.
 * Assumes binding into the top module; one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module odr_sva #(
	parameter int ADDR_W = 12
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [3:0]        hiz_request_pin_n,
	input wire logic [11:0]       motor_hiz_force,
	input wire logic              request_irq,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] low_hist_q;
	// Recent history of any request pin low
	always_ff @(posedge clk) begin
		low_hist_q <= rst_n ? {low_hist_q[6:0], ~&hiz_request_pin_n} : 8'h00;
	end
	chk_force_same: assert property (motor_hiz_force == {12{motor_hiz_force[0]}})
		else $error("force bits differ");
	chk_irq_flag: assert property (request_irq |-> motor_hiz_force[0])
		else $error("irq without flag");
	chk_force_cause: assert property ($rose(motor_hiz_force[0]) |-> |low_hist_q)
		else $error("force without low pin");
	chk_force_release: assert property ($fell(motor_hiz_force[0]) |-> $rose(bvalid))
		else $error("force released without clear");
	chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	chk_write_bad: assert property (awvalid && awready && wvalid && wready
		&& awaddr[ADDR_W-1:2] != '0 |-> ##2 bvalid && bresp == 2'h2)
		else $error("unmapped write answer");
	chk_read_zero: assert property (arvalid && arready |=> rvalid
		&& rdata[31:16] == 16'h0000 && rdata[11:9] == 3'h0)
		else $error("reserved bits set");
	chk_read_bad: assert property (arvalid && arready && araddr[ADDR_W-1:2] != '0
		|=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read answer");
	cov_force: cover property ($rose(motor_hiz_force[0]));
	cov_irq: cover property ($rose(request_irq));
	cov_err: cover property (bvalid && bresp == 2'h2);
endmodule : odr_sva
bind output_disable_request_detector odr_sva #(.ADDR_W(ADDR_W)) odr_sva_i (
	.clk(clk), .rst_n(rst_n), .hiz_request_pin_n(hiz_request_pin_n),
	.motor_hiz_force(motor_hiz_force), .request_irq(request_irq), .awaddr(awaddr),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready));
`default_nettype wire

// [testbench/test_output_disable_request_detector.sv]
/*
 * Self-checking bench of the output disable request detector.
 * Assumes the fault source model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module test_output_disable_request_detector;
	logic        clk     = 1'h0;
	logic        rst_n   = 1'h0;
	logic [3:0]  lvl_n   = 4'hF;
	logic        slow    = 1'h0;
	logic [3:0]  pin_n;
	logic [11:0] hiz;
	logic        irq;
	logic [11:0] awaddr  = 12'h000;
	logic [11:0] araddr  = 12'h000;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid  = 1'h0;
	logic        bready  = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready  = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rdv, v;
	int          mismatches   = 0;
	int          total_checks = 0;
	int          p;
	output_disable_request_detector output_disable_request_detector_i (
		.clk(clk), .rst_n(rst_n), .hiz_request_pin_n(pin_n), .motor_hiz_force(hiz),
		.request_irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	fault_source fault_source_i (.clk(clk), .level_n(lvl_n), .slow(slow), .pin_n(pin_n));
	// Clock at 125 MHz
	initial forever #4 clk = ~clk;
	// Sampling tick period of a level mode
	function automatic int div_of(input int m);
		return (m == 1) ? 8 : (m == 2) ? 16 : 128;
	endfunction : div_of
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Write, both channels offered together, answer taken after a random stall
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		repeat ($urandom_range(2)) @(posedge clk);
		bready <= 1'h1;
		do @(posedge clk); while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
		#1;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		araddr  <= a;
		arvalid <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		repeat ($urandom_range(2)) @(posedge clk);
		rready <= 1'h1;
		do @(posedge clk); while (!rvalid);
		rdv = rdata;
		resp = rresp;
		rready <= 1'h0;
		#1;
	endtask : rd
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h774B));
		tick(5);
		rst_n <= 1'h1;
		tick(1);
		rd(12'h000);
		chk(rdv, 32'h0);
		chk({irq, hiz}, 13'h0000);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			v = $urandom;
			wr(12'h000, v & 32'hFFFFF1FF);
			rd(12'h000);
			chk(rdv, v & 32'h1FF);
		end
		wr(12'h004, 32'h1FF);
		chk(resp, 2'h2);
		rd(12'h004);
		chk(resp, 2'h2);
		chk(rdv, 32'h0);
		$display("register test done");
		wr(12'h000, 32'h100);
		for (int i = 0; i < 4; i++) begin
			slow  <= 1'($urandom_range(1));
			lvl_n <= ~(4'h1 << i);
			tick(8);
			chk({irq, hiz}, 13'h1FFF);
			wr(12'h000, 32'h100);
			rd(12'h000);
			chk(rdv, 32'h100 | (32'h1 << (12 + i)));
			// Writing one to an armed flag leaves it set
			wr(12'h000, 32'h100 | (32'h1 << (12 + i)));
			rd(12'h000);
			chk(rdv, 32'h100 | (32'h1 << (12 + i)));
			lvl_n <= 4'hF;
			wr(12'h000, 32'h100);
			tick(2);
			chk({irq, hiz}, 13'h0000);
		end
		$display("edge test done");
		for (int m = 1; m < 4; m++) begin
			p = $urandom_range(3);
			wr(12'h000, 32'(m) << (2 * p));
			tick(2 * div_of(m));
			lvl_n <= ~(4'h1 << p);
			tick(14 * div_of(m));
			// One high sample splits 14 + 8 low samples
			lvl_n <= 4'hF;
			tick(div_of(m));
			lvl_n <= ~(4'h1 << p);
			tick(8 * div_of(m));
			lvl_n <= 4'hF;
			tick(2 * div_of(m));
			rd(12'h000);
			chk(rdv, 32'(m) << (2 * p));
			lvl_n <= ~(4'h1 << p);
			tick(17 * div_of(m) + 8);
			rd(12'h000);
			chk(rdv, (32'(m) << (2 * p)) | (32'h1 << (12 + p)));
			chk({irq, hiz}, 13'h0FFF);
			lvl_n <= 4'hF;
			wr(12'h000, 32'(m) << (2 * p));
			tick(2);
			chk(hiz, 12'h000);
		end
		$display("level test done");
		tally_and_finish();
	end
endmodule : test_output_disable_request_detector
`default_nettype wire
